// >>> hdl/opm_pkg.sv
// shared constants, kinds and carriers for the output image mapper
package opm_pkg;

  // object directory indexes used by the output image
  localparam logic [15:0] PACK_OBJ_INDEX = 16'h4500;   // packing mode object
  localparam logic [7:0]  PACK_OBJ_SUB   = 8'h00;      // packing mode subindex
  localparam logic [15:0] AO_OBJ_INDEX   = 16'h6411;   // analog output object
  localparam logic [15:0] DO_OBJ_INDEX   = 16'h6200;   // discrete output object
  localparam logic [15:0] FPC_OBJ_INDEX  = 16'h3200;   // counter output object
  localparam logic [15:0] NO_OBJ_INDEX   = 16'h0000;   // byte beyond the image
  localparam logic [7:0]  SUB_FIRST      = 8'h01;      // first subindex of any span
  localparam logic [7:0]  SUB_NONE       = 8'h00;      // subindex beyond the image

  // packing modes
  localparam logic PACK_UNCOMPRESSED = 1'b0;
  localparam logic PACK_COMPRESSED   = 1'b1;
  localparam logic PACK_RESET        = PACK_UNCOMPRESSED;  // mode after reset

  // image geometry
  localparam int BYTE_BITS   = 8;    // bits per image byte
  localparam int SLOT_BITS   = 32;   // widest slot payload
  localparam int MAX_SLOTS   = 16;   // largest slot count the layout serves
  localparam int ADAPTER_SLOT = 0;   // adapter position, carries no outputs

  // slot data groups, in image order
  localparam int GRP_ANALOG   = 0;
  localparam int GRP_DISCRETE = 1;
  localparam int GRP_COUNTER  = 2;
  localparam int GRP_NONE     = 3;

  // kind of module installed in a slot
  typedef enum logic [2:0] {
    OPM_NONE = 3'h0,   // empty or input-only slot
    OPM_DO2  = 3'h1,   // 2-point discrete or relay output
    OPM_DO4  = 3'h2,   // 4-point discrete output
    OPM_DO8  = 3'h3,   // 8-point discrete output
    OPM_DO16 = 3'h4,   // 16-point discrete output
    OPM_AO2  = 3'h5,   // 2-channel analog output
    OPM_FPC  = 3'h6    // fast pulse counter output word
  } opm_slot_kind_t;

  // one byte of the incoming output image
  typedef struct packed {
    logic       first;   // byte 0 of a new image
    logic [7:0] data;    // image byte
  } opm_beat_t;

  // one object write from the master
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
    logic [7:0]  data;
  } opm_obj_wr_t;

  // object reference of an image byte
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
  } opm_map_t;

  // payload bits a slot kind carries
  function automatic int kind_bits(opm_slot_kind_t k);
    case (k)
      OPM_DO2:  return 2;
      OPM_DO4:  return 4;
      OPM_DO8:  return 8;
      OPM_DO16: return 16;
      OPM_AO2:  return 32;
      OPM_FPC:  return 16;
      default:  return 0;
    endcase
  endfunction

  // group a slot kind belongs to
  function automatic int kind_group(opm_slot_kind_t k);
    case (k)
      OPM_AO2:  return GRP_ANALOG;
      OPM_FPC:  return GRP_COUNTER;
      OPM_NONE: return GRP_NONE;
      default:  return GRP_DISCRETE;
    endcase
  endfunction

endpackage

// >>> hdl/opm_layout.sv
// combinational image layout: where each slot's bits sit in the output image
`timescale 1ns/1ps
module opm_layout import opm_pkg::*; #(
  parameter int NSLOT = 12,
  parameter int PW    = 10
) (
  input  wire logic           pack_mode_in,
  input  opm_slot_kind_t      kind_in   [NSLOT],
  output logic [PW-1:0]       start_out [NSLOT],
  output logic [5:0]          width_out [NSLOT],
  output logic [PW-4:0]       ao_end_out,
  output logic [PW-4:0]       do_end_out,
  output logic [PW-4:0]       img_end_out
);

  // walk the groups in image order, slots in ascending order inside each
  always_comb begin
    int cur;
    int w;
    cur = 0;
    w   = 0;
    ao_end_out = '0;
    do_end_out = '0;
    for (int s = 0; s < NSLOT; s++) begin
      start_out[s] = '0;
      width_out[s] = '0;
    end
    for (int g = GRP_ANALOG; g <= GRP_COUNTER; g++) begin
      // every group opens on a fresh byte
      cur = (cur + BYTE_BITS - 1) / BYTE_BITS * BYTE_BITS;
      if (g == GRP_DISCRETE) begin
        ao_end_out = (PW-3)'(cur / BYTE_BITS);
      end
      if (g == GRP_COUNTER) begin
        do_end_out = (PW-3)'(cur / BYTE_BITS);
      end
      // slot zero is the adapter and is skipped
      for (int s = ADAPTER_SLOT + 1; s < NSLOT; s++) begin
        if (kind_group(kind_in[s]) == g) begin
          w = kind_bits(kind_in[s]);
          start_out[s] = PW'(cur);
          width_out[s] = 6'(w);
          if (pack_mode_in == PACK_COMPRESSED) begin
            cur = cur + w;
          end else begin
            cur = cur + (w + BYTE_BITS - 1) / BYTE_BITS * BYTE_BITS;
          end
        end
      end
    end
    img_end_out = (PW-3)'((cur + BYTE_BITS - 1) / BYTE_BITS);
  end

endmodule

// >>> hdl/opm_out_image_mapper.sv
// output process image mapper: image bytes from the master onto output slots
`timescale 1ns/1ps
module opm_out_image_mapper import opm_pkg::*; #(
  parameter int NSLOT = 12    // slot count including the adapter slot
) (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_b_in,
  input  wire logic           obj_wr_valid_in,
  input  opm_obj_wr_t         obj_wr_in,
  input  opm_slot_kind_t      slot_kind_in   [NSLOT],
  input  wire logic           beat_valid_in,
  input  opm_beat_t           beat_in,
  output logic [31:0]         slot_data_out  [NSLOT],
  output logic                map_valid_out,
  output opm_map_t            map_out,
  output logic                pack_mode_out,
  output logic [7:0]          image_bytes_out
);

  localparam int PW = $clog2(NSLOT * SLOT_BITS) + 1;  // image bit position width
  localparam int BW = PW - 3;                          // image byte index width

  // elaboration check: the layout walk and byte index are sized for this range
  if (NSLOT < 2 || NSLOT > MAX_SLOTS) begin : g_bad_nslot
    $error("NSLOT must lie between 2 and MAX_SLOTS");
  end

  // reset release through two flops; assertion is still asynchronous
  logic rst_meta_r;   // first stage, read only by the second
  logic rst_sync_r;   // design-wide active-low reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // packing mode, written by the master through its object
  logic pack_mode_r;    // current packing mode
  logic pack_mode_nxt;  // next packing mode
  always_comb begin
    pack_mode_nxt = pack_mode_r;
    // only the exact index and subindex steer the mode
    if (obj_wr_valid_in && obj_wr_in.index == PACK_OBJ_INDEX
        && obj_wr_in.sub == PACK_OBJ_SUB) begin
      pack_mode_nxt = obj_wr_in.data[0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pack_mode_r <= PACK_RESET;
    end else begin
      pack_mode_r <= pack_mode_nxt;
    end
  end

  // layout of the image for the installed modules and current mode
  logic [PW-1:0] lay_start [NSLOT];   // first image bit of each slot
  logic [5:0]    lay_width [NSLOT];   // payload bits of each slot
  logic [BW-1:0] ao_end;              // first byte after the analog group
  logic [BW-1:0] do_end;              // first byte after the discrete group
  logic [BW-1:0] img_end;             // total image bytes

  opm_layout #(
    .NSLOT (NSLOT),
    .PW    (PW)
  ) u_layout (
    .pack_mode_in (pack_mode_r),
    .kind_in      (slot_kind_in),
    .start_out    (lay_start),
    .width_out    (lay_width),
    .ao_end_out   (ao_end),
    .do_end_out   (do_end),
    .img_end_out  (img_end)
  );

  // byte position inside the image being received
  logic [BW-1:0] pos_r;     // index the next non-first byte takes
  logic [BW-1:0] pos_nxt;
  logic [BW-1:0] cur_b;     // index of the byte on the input now
  always_comb begin
    cur_b   = beat_in.first ? '0 : pos_r;
    pos_nxt = pos_r;
    // saturate so an overlong image cannot wrap onto the analog bytes
    if (beat_valid_in && cur_b != '1) begin
      pos_nxt = cur_b + BW'(1);
    end else if (beat_valid_in) begin
      pos_nxt = cur_b;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // per-slot output data: each bit takes the image bit that lands on it
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    logic [31:0] data_r;     // held output word of this slot
    logic [31:0] data_nxt;
    always_comb begin
      logic [PW-1:0] p;
      p        = '0;
      data_nxt = data_r;
      for (int k = 0; k < SLOT_BITS; k++) begin
        p = lay_start[s] + PW'(k);
        if (6'(k) >= lay_width[s]) begin
          // reserved and unused positions never reach the module
          data_nxt[k] = 1'b0;
        end else if (beat_valid_in && p[PW-1:3] == cur_b) begin
          // low byte first falls out of ascending bit positions
          data_nxt[k] = beat_in.data[p[2:0]];
        end
      end
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
        data_r <= '0;
      end else begin
        data_r <= data_nxt;
      end
    end

    assign slot_data_out[s] = data_r;

    property p_narrow_clear;
      @(posedge ref_clk_in) disable iff (!rst_sync_r)
      (lay_width[s] == 6'd4) |=> (data_r[31:4] == 28'h0);
    endproperty
    a_narrow_clear: assert property (p_narrow_clear)
      else $error("bits above a 4-point slot are not clear");
  end

  // object reference of each received byte
  opm_map_t map_r;
  opm_map_t map_nxt;
  logic     map_valid_r;
  logic     map_valid_nxt;
  always_comb begin
    map_valid_nxt = beat_valid_in;
    map_nxt       = map_r;
    if (beat_valid_in) begin
      if (cur_b < ao_end) begin
        // two bytes per analog channel
        map_nxt.index = AO_OBJ_INDEX;
        map_nxt.sub   = 8'(cur_b >> 1) + SUB_FIRST;
      end else if (cur_b < do_end) begin
        // one subindex per discrete byte
        map_nxt.index = DO_OBJ_INDEX;
        map_nxt.sub   = 8'(cur_b - ao_end) + SUB_FIRST;
      end else if (cur_b < img_end) begin
        map_nxt.index = FPC_OBJ_INDEX;
        map_nxt.sub   = 8'(cur_b - do_end) + SUB_FIRST;
      end else begin
        map_nxt.index = NO_OBJ_INDEX;
        map_nxt.sub   = SUB_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      map_r       <= '{index: NO_OBJ_INDEX, sub: SUB_NONE};
      map_valid_r <= 1'b0;
    end else begin
      map_r       <= map_nxt;
      map_valid_r <= map_valid_nxt;
    end
  end

  // image length, registered so the port comes straight from a flop
  logic [7:0] img_len_r;
  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      img_len_r <= 8'h00;
    end else begin
      img_len_r <= 8'(img_end);
    end
  end

  assign map_valid_out   = map_valid_r;
  assign map_out         = map_r;
  assign pack_mode_out   = pack_mode_r;
  assign image_bytes_out = img_len_r;

  // helper: any slot off a byte boundary
  logic any_unaligned;
  always_comb begin
    any_unaligned = 1'b0;
    for (int s = 0; s < NSLOT; s++) begin
      if (lay_width[s] != 6'd0 && lay_start[s][2:0] != 3'h0) begin
        any_unaligned = 1'b1;
      end
    end
  end

  property p_unpacked_align;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (pack_mode_r == PACK_UNCOMPRESSED) |-> !any_unaligned;
  endproperty
  a_unpacked_align: assert property (p_unpacked_align)
    else $error("uncompressed slot not byte aligned");

  property p_group_order;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (ao_end <= do_end) && (do_end <= img_end);
  endproperty
  a_group_order: assert property (p_group_order)
    else $error("image groups out of order");

  property p_mode_write;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (obj_wr_valid_in && obj_wr_in.index == PACK_OBJ_INDEX && obj_wr_in.sub == PACK_OBJ_SUB)
      |=> (pack_mode_out == $past(obj_wr_in.data[0]));
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("packing mode write not applied");

  property p_adapter_empty;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (lay_width[ADAPTER_SLOT] == 6'd0) ##1 (slot_data_out[ADAPTER_SLOT] == 32'h0);
  endproperty
  a_adapter_empty: assert property (p_adapter_empty)
    else $error("adapter slot carries output data");

  property p_analog_sub;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (beat_valid_in && cur_b < ao_end)
      |=> (map_out.index == AO_OBJ_INDEX) && (map_out.sub == 8'($past(cur_b) >> 1) + SUB_FIRST);
  endproperty
  a_analog_sub: assert property (p_analog_sub)
    else $error("analog byte mapped to wrong subindex");

  property p_analog_first;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (beat_valid_in && beat_in.first && ao_end != '0)
      |=> map_valid_out && map_out.index == AO_OBJ_INDEX && map_out.sub == SUB_FIRST;
  endproperty
  a_analog_first: assert property (p_analog_first)
    else $error("image does not open with analog channel one");

  property p_discrete_sub;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (beat_valid_in && cur_b >= ao_end && cur_b < do_end)
      |=> (map_out.index == DO_OBJ_INDEX) && (map_out.sub == 8'($past(cur_b) - $past(ao_end)) + SUB_FIRST);
  endproperty
  a_discrete_sub: assert property (p_discrete_sub)
    else $error("discrete byte mapped to wrong subindex");

  property p_counter_pair;
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (beat_valid_in && !beat_in.first && cur_b == do_end && do_end < img_end)
      |=> (map_out.index == FPC_OBJ_INDEX) && (map_out.sub == SUB_FIRST);
  endproperty
  a_counter_pair: assert property (p_counter_pair)
    else $error("counter low byte not on subindex one");

endmodule

// >>> bench/opm_master_model.sv
// master model: feeds image bytes and object writes toward the mapper
`timescale 1ns/1ps
module opm_master_model import opm_pkg::*; (
  input  wire logic   clk_in,
  output logic        beat_valid_out,
  output opm_beat_t   beat_out,
  output logic        obj_wr_valid_out,
  output opm_obj_wr_t obj_wr_out
);
  // quiet bus from time zero
  initial begin
    beat_valid_out   = 1'b0;
    beat_out         = '0;
    obj_wr_valid_out = 1'b0;
    obj_wr_out       = '0;
  end

  // one image byte, changed after the falling edge and held a full cycle
  task automatic send_byte(input logic first, input logic [7:0] d);
    @(negedge clk_in);
    beat_valid_out = 1'b1;
    beat_out       = '{first: first, data: d};
  endtask

  // object write; the mapper only honours the packing mode object
  task automatic write_obj(input logic [15:0] idx, input logic [7:0] sub, input logic [7:0] d);
    @(negedge clk_in);
    obj_wr_valid_out = 1'b1;
    obj_wr_out       = '{index: idx, sub: sub, data: d};
  endtask

  // strobes drop; released fields flip so a stale value can never pass
  task automatic idle();
    @(negedge clk_in);
    beat_valid_out   = 1'b0;
    obj_wr_valid_out = 1'b0;
    beat_out         = ~beat_out;
    obj_wr_out       = ~obj_wr_out;
  endtask
endmodule

// >>> bench/opm_out_image_mapper_test.sv
// self-checking bench for the output image mapper
`timescale 1ns/1ps
module opm_out_image_mapper_test import opm_pkg::*;;
  localparam int NS = 12;                 // adapter slot plus eleven modules
  logic           ref_clk = 1'b0;         // 125 MHz
  logic           rst_b   = 1'b0;         // active low reset
  logic           bv;                     // byte strobe
  logic           ov;                     // object write strobe
  opm_beat_t      beat;                   // image byte
  opm_obj_wr_t    ow;                     // object write
  opm_slot_kind_t kinds [NS];             // slot configuration
  logic [31:0]    sdata [NS];             // slot words seen
  logic           mv;                     // map strobe seen
  logic           pm;                     // packing mode seen
  opm_map_t       mp;                     // map seen
  logic [7:0]     nbytes;                 // image length seen
  int             n_mismatch = 0;
  int             n_compared = 0;
  int             st [NS];                // expected start bit per slot
  int             ao_end, do_end, img_end, cur_idx;
  logic           taken = 1'b0;           // byte accepted last edge
  logic           mon_on = 1'b0;          // byte monitor armed
  logic           mode = 1'b0;            // mode the expectations use
  logic [7:0]     img [24];               // image bytes sent

  // free running clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  opm_master_model mst (
    .clk_in           (ref_clk),
    .beat_valid_out   (bv),
    .beat_out         (beat),
    .obj_wr_valid_out (ov),
    .obj_wr_out       (ow)
  );

  opm_out_image_mapper #(.NSLOT(NS)) dut (
    .ref_clk_in      (ref_clk),
    .rst_b_in        (rst_b),
    .obj_wr_valid_in (ov),
    .obj_wr_in       (ow),
    .slot_kind_in    (kinds),
    .beat_valid_in   (bv),
    .beat_in         (beat),
    .slot_data_out   (sdata),
    .map_valid_out   (mv),
    .map_out         (mp),
    .pack_mode_out   (pm),
    .image_bytes_out (nbytes)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // payload width and group of a slot kind, worked out independently
  task automatic kw(input opm_slot_kind_t k, output int w, output int g);
    g = 1;
    case (k)
      OPM_DO2:  w = 2;
      OPM_DO4:  w = 4;
      OPM_DO8:  w = 8;
      OPM_DO16: w = 16;
      OPM_AO2: begin
        w = 32;
        g = 0;
      end
      OPM_FPC: begin
        w = 16;
        g = 2;
      end
      default:  w = 0;
    endcase
  endtask

  // expected layout: analog, discrete, counter; groups start on a byte
  task automatic build_exp();
    int pos, w, g;
    pos = 0;
    for (int gr = 0; gr < 3; gr++) begin
      for (int s = 1; s < NS; s++) begin
        kw(kinds[s], w, g);
        if (g == gr && w > 0) begin
          if (!mode) pos = (pos + 7) / 8 * 8;
          st[s] = pos;
          pos += w;
        end
      end
      pos = (pos + 7) / 8 * 8;
      if (gr == 0) ao_end = pos / 8;
      if (gr == 1) do_end = pos / 8;
    end
    img_end = pos / 8;
  endtask

  function automatic opm_map_t exp_map(int b);
    if (b < ao_end) return '{AO_OBJ_INDEX, 8'(b / 2 + 1)};
    if (b < do_end) return '{DO_OBJ_INDEX, 8'(b - ao_end + 1)};
    if (b < img_end) return '{FPC_OBJ_INDEX, 8'(b - do_end + 1)};
    return '{NO_OBJ_INDEX, SUB_NONE};
  endfunction

  // track which image byte the mapper took, then judge its map pulse
  always @(posedge ref_clk) begin
    taken <= bv;
    if (bv) cur_idx <= beat.first ? 0 : cur_idx + 1;
  end
  always @(negedge ref_clk) begin
    if (mon_on) begin
      chk("map_valid", 32'(taken), 32'(mv));
      if (taken) chk("map", 32'(exp_map(cur_idx)), 32'(mp));
    end
  end

  // set mode, send one whole image plus one stray byte, compare slots
  task automatic t_image(input logic m, input bit gap, input logic [7:0] seed);
    logic [31:0] e;
    int w, g;
    mst.write_obj(PACK_OBJ_INDEX, PACK_OBJ_SUB, {7'h00, m});
    mst.idle();
    mst.idle();
    mode = m;
    build_exp();
    chk("pack_mode", 32'(m), 32'(pm));
    chk("image_bytes", 32'(img_end), 32'(nbytes));
    for (int b = 0; b < 24; b++) img[b] = 8'(b * 37) + seed;
    for (int b = 0; b <= img_end; b++) begin
      mst.send_byte(b == 0, img[b]);
      if (gap) mst.idle();
    end
    mst.idle();
    mst.idle();
    for (int s = 0; s < NS; s++) begin
      kw(kinds[s], w, g);
      e = '0;
      for (int k = 0; k < w; k++) e[k] = img[(st[s] + k) / 8][(st[s] + k) % 8];
      chk($sformatf("slot%0d", s), e, sdata[s]);
    end
  endtask

  task automatic t_reset();
    chk("reset mode", 32'(PACK_RESET), 32'(pm));
    chk("reset bytes", 32'h0, 32'(nbytes));
    chk("reset map", 32'h0, 32'(mp));
    chk("reset slot", 32'h0, sdata[1]);
    chk("reset valid", 32'h0, 32'(mv));
  endtask

  // set the mode first so that a foreign write of zero would show up as a change
  task automatic t_mode();
    mst.write_obj(PACK_OBJ_INDEX, PACK_OBJ_SUB, 8'h03);
    mst.idle();
    chk("mode set", 32'h1, 32'(pm));
    mst.write_obj(16'h4501, PACK_OBJ_SUB, 8'h00);
    mst.write_obj(PACK_OBJ_INDEX, 8'h01, 8'h00);
    mst.idle();
    chk("mode kept", 32'h1, 32'(pm));
    mst.write_obj(PACK_OBJ_INDEX, PACK_OBJ_SUB, 8'hfe);
    mst.idle();
    chk("mode bit0", 32'h0, 32'(pm));
  endtask

  // full slot table in both modes, slow master in the second
  task automatic t_table();
    t_image(PACK_COMPRESSED, 1'b0, 8'h05);
    t_image(PACK_UNCOMPRESSED, 1'b1, 8'h3c);
  endtask

  // two four-point modules share a byte only when compressed
  task automatic t_nibbles();
    kinds = '{default: OPM_NONE};
    kinds[1] = OPM_DO4;
    kinds[2] = OPM_DO4;
    t_image(PACK_COMPRESSED, 1'b0, 8'h21);
    t_image(PACK_UNCOMPRESSED, 1'b0, 8'h9a);
  endtask

  // main sequence
  initial begin
    kinds = '{OPM_NONE, OPM_DO4, OPM_DO8, OPM_AO2, OPM_DO16, OPM_DO4,
              OPM_DO8, OPM_DO2, OPM_DO2, OPM_AO2, OPM_DO16, OPM_FPC};
    repeat (20) @(negedge ref_clk);
    t_reset();
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    mon_on = 1'b1;
    t_mode();
    t_table();
    t_nibbles();
    tally_and_finish();
  end

  // watchdog, far beyond the roughly 120 cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    $display("Error watchdog expired");
    tally_and_finish();
  end
endmodule
